// File: rtl/tpsdp_port.sv
`timescale 1ns/1ns
`include "tpsdp_map.svh"

// Operation
// - while the system reset pin is low all eight test points are inputs and undriven.
// - after the system reset pin is released the test points become outputs, driven or floating per mode.
// - the pin levels caught at reset release set the mode, and later pin changes are ignored.
// - the strap is caught only on a low-to-high edge of the system reset pin.
// - each pin has a pull-down, so an unstrapped pin is caught as zero.
// - strap code zero leaves every test point floating after reset.
// - strap code two drives debug clocks on points 0, 1, 2 and 7, high on 3, 5, 6 and low on 4.
// - the strap choice is only a default, and software may reselect any point while the port is running.
// - only the three lowest pins form the strap code; the upper five are not strapped.
module tpsdp_port
  import tpsdp_pkg::*;
(
  // clock and block reset
  input  wire logic                         clock,
  input  wire logic                         reset,
  // system reset pin, active low
  input  wire logic                         system_reset_low,
  // test point pins
  input  wire logic [`TPSDP_NUM_POINTS-1:0] test_point_bus_in,
  output logic      [`TPSDP_NUM_POINTS-1:0] test_point_bus_out,
  output logic      [`TPSDP_NUM_POINTS-1:0] test_point_bus_oe,
  // internal debug clock sources
  input  wire logic                         dbg_clk_60,
  input  wire logic                         dbg_clk_30,
  input  wire logic                         dbg_clk_var,
  input  wire logic                         dbg_clk_7p5,
  // software reselection of one point
  input  wire logic                         sel_write,
  input  wire logic [2:0]                   sel_point,
  input  wire tpsdp_src_e                   sel_source,
  // status
  output logic      [`TPSDP_STRAP_W-1:0]    test_mode_strap_bits,
  output logic                              port_active
);

  logic [`TPSDP_SYNC_W-1:0]    sync_out;
  logic [`TPSDP_NUM_POINTS-1:0] pins_s;
  logic                         sys_rst_n_s;
  logic                         rst_rise;
  logic                         rst_n_prev_q;
  logic                         rst_n_prev_d;
  tpsdp_state_e                 state_q;
  tpsdp_state_e                 state_d;
  logic [`TPSDP_STRAP_W-1:0]    strap_q;
  logic [`TPSDP_STRAP_W-1:0]    strap_d;
  tpsdp_src_e                   sel_q [`TPSDP_NUM_POINTS];
  tpsdp_src_e                   sel_d [`TPSDP_NUM_POINTS];

  // pins and reset pin come from outside the clock domain
  tpsdp_sync u_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in ({system_reset_low, test_point_bus_in}),
    .sync_out (sync_out)
  );

  assign pins_s      = sync_out[`TPSDP_NUM_POINTS-1:0];
  assign sys_rst_n_s = sync_out[`TPSDP_NUM_POINTS];
  // both share the same latency, so the strap is aligned with the edge
  assign rst_rise    = sys_rst_n_s & ~rst_n_prev_q;

  // default selection of one point for a given strap code
  function automatic tpsdp_src_e strap_default(
    input logic [`TPSDP_STRAP_W-1:0] code,
    input int unsigned               idx
  );
    tpsdp_src_e r;
    r = src_hiz;
    if (code == `TPSDP_CODE_CLKDBG) begin
      case (idx)
        `TPSDP_PT_CLK60:  r = src_clk60;
        `TPSDP_PT_CLK30:  r = src_clk30;
        `TPSDP_PT_CLKVAR: r = src_clkvar;
        `TPSDP_PT_LOW:    r = src_low;
        `TPSDP_PT_CLK7P5: r = src_clk7p5;
        default:          r = src_high;
      endcase
    end else begin
      // quiet code and undefined codes both float
      r = src_hiz;
    end
    return r;
  endfunction : strap_default

  // next state, strap and selections
  always_comb begin
    rst_n_prev_d = sys_rst_n_s;
    state_d      = state_q;
    strap_d      = strap_q;
    for (int i = 0; i < `TPSDP_NUM_POINTS; i++) begin
      sel_d[i] = sel_q[i];
    end
    if (!sys_rst_n_s) begin
      // pins are inputs while held in reset
      state_d = st_hold;
      for (int i = 0; i < `TPSDP_NUM_POINTS; i++) begin
        sel_d[i] = src_hiz;
      end
    end else if (rst_rise) begin
      // only the low bits count; pull-downs make open pins read zero
      strap_d = pins_s[`TPSDP_STRAP_MSB:`TPSDP_STRAP_LSB];
      state_d = st_run;
      for (int i = 0; i < `TPSDP_NUM_POINTS; i++) begin
        sel_d[i] = strap_default(pins_s[`TPSDP_STRAP_MSB:`TPSDP_STRAP_LSB], i);
      end
    end else if (state_q == st_run && sel_write) begin
      // capture wins over a write in the same cycle
      sel_d[sel_point] = sel_source;
    end
  end

  // registers only
  always_ff @(posedge clock) begin
    if (reset) begin
      rst_n_prev_q <= 1'h0;
      state_q      <= st_hold;
      strap_q      <= `TPSDP_STRAP_RST;
      for (int i = 0; i < `TPSDP_NUM_POINTS; i++) begin
        sel_q[i] <= src_hiz;
      end
    end else begin
      rst_n_prev_q <= rst_n_prev_d;
      state_q      <= state_d;
      strap_q      <= strap_d;
      for (int i = 0; i < `TPSDP_NUM_POINTS; i++) begin
        sel_q[i] <= sel_d[i];
      end
    end
  end

  // per-point output mux; clocks cannot be re-registered at this rate
  genvar g;
  generate
    for (g = 0; g < `TPSDP_NUM_POINTS; g++) begin : g_point
      logic pt_out;
      // hiz and low both give 0; the enable decides whether it reaches the pad
      always_comb begin
        case (sel_q[g])
          src_high:   pt_out = 1'h1;
          src_clk60:  pt_out = dbg_clk_60;
          src_clk30:  pt_out = dbg_clk_30;
          src_clkvar: pt_out = dbg_clk_var;
          src_clk7p5: pt_out = dbg_clk_7p5;
          default:    pt_out = 1'h0;
        endcase
      end
      assign test_point_bus_out[g] = pt_out;
      // drive only when running and selected
      assign test_point_bus_oe[g] = (state_q == st_run) && (sel_q[g] != src_hiz);
    end
  endgenerate

  assign test_mode_strap_bits = strap_q;
  assign port_active          = (state_q == st_run);

  // checks
  property p_hold_undriven;
    @(posedge clock) disable iff (reset)
      !sys_rst_n_s |=> (test_point_bus_oe == `TPSDP_OE_OFF) && !port_active;
  endproperty
  a_hold_undriven: assert property (p_hold_undriven)
    else $error("test point driven while held in reset");

  property p_fall_release;
    @(posedge clock) disable iff (reset)
      $fell(sys_rst_n_s) |=> (test_point_bus_oe == `TPSDP_OE_OFF) && !port_active;
  endproperty
  a_fall_release: assert property (p_fall_release)
    else $error("pins not released after reset asserted");

  property p_run_after_rise;
    @(posedge clock) disable iff (reset)
      rst_rise |=> port_active;
  endproperty
  a_run_after_rise: assert property (p_run_after_rise)
    else $error("port not active after reset release");

  property p_strap_stable;
    @(posedge clock) disable iff (reset)
      (port_active && sys_rst_n_s && !rst_rise) |=> $stable(strap_q);
  endproperty
  a_strap_stable: assert property (p_strap_stable)
    else $error("strap changed without a reset release");

  property p_strap_capture;
    @(posedge clock) disable iff (reset)
      rst_rise |=> strap_q == $past(pins_s[`TPSDP_STRAP_MSB:`TPSDP_STRAP_LSB]);
  endproperty
  a_strap_capture: assert property (p_strap_capture)
    else $error("strap not caught from low pins at release");

  property p_no_rise_no_change;
    @(posedge clock) disable iff (reset)
      !rst_rise |=> strap_q == $past(strap_q);
  endproperty
  a_no_rise_no_change: assert property (p_no_rise_no_change)
    else $error("strap changed outside a reset edge");

  property p_quiet;
    @(posedge clock) disable iff (reset)
      (rst_rise && pins_s[`TPSDP_STRAP_MSB:`TPSDP_STRAP_LSB] == `TPSDP_CODE_QUIET)
        |=> (test_point_bus_oe == `TPSDP_OE_OFF) && port_active;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("quiet strap drives a point");

  property p_clkdbg;
    @(posedge clock) disable iff (reset)
      (rst_rise && pins_s[`TPSDP_STRAP_MSB:`TPSDP_STRAP_LSB] == `TPSDP_CODE_CLKDBG)
        |=> (&test_point_bus_oe)
            && ((test_point_bus_out & `TPSDP_LVL_MASK) == `TPSDP_LVL_CLKDBG)
            && sel_q[`TPSDP_PT_CLK60] == src_clk60 && sel_q[`TPSDP_PT_CLK30] == src_clk30
            && sel_q[`TPSDP_PT_CLKVAR] == src_clkvar
            && sel_q[`TPSDP_PT_CLK7P5] == src_clk7p5;
  endproperty
  a_clkdbg: assert property (p_clkdbg)
    else $error("clock debug defaults wrong");

  property p_sw_select;
    @(posedge clock) disable iff (reset)
      (port_active && sys_rst_n_s && !rst_rise && sel_write)
        |=> sel_q[$past(sel_point)] == $past(sel_source);
  endproperty
  a_sw_select: assert property (p_sw_select)
    else $error("software selection not applied");

  property p_undefined;
    @(posedge clock) disable iff (reset)
      (rst_rise && pins_s[`TPSDP_STRAP_MSB:`TPSDP_STRAP_LSB] != `TPSDP_CODE_QUIET
        && pins_s[`TPSDP_STRAP_MSB:`TPSDP_STRAP_LSB] != `TPSDP_CODE_CLKDBG)
        |=> test_point_bus_oe == `TPSDP_OE_OFF;
  endproperty
  a_undefined: assert property (p_undefined)
    else $error("undefined strap drives a point");

  c_quiet: cover property (@(posedge clock) disable iff (reset)
    rst_rise && pins_s[`TPSDP_STRAP_MSB:`TPSDP_STRAP_LSB] == `TPSDP_CODE_QUIET);
  c_clkdbg: cover property (@(posedge clock) disable iff (reset)
    rst_rise && pins_s[`TPSDP_STRAP_MSB:`TPSDP_STRAP_LSB] == `TPSDP_CODE_CLKDBG);
  c_sw_write: cover property (@(posedge clock) disable iff (reset)
    port_active && sel_write ##1 port_active);

endmodule : tpsdp_port

// File: rtl/tpsdp_map.svh
`ifndef TPSDP_MAP_SVH
`define TPSDP_MAP_SVH

// pin counts and strap field position
`define TPSDP_NUM_POINTS  8
`define TPSDP_STRAP_W     3
`define TPSDP_STRAP_MSB   2
`define TPSDP_STRAP_LSB   0
`define TPSDP_SYNC_W      9

// strap codes with a defined meaning
`define TPSDP_CODE_QUIET  3'h0
`define TPSDP_CODE_CLKDBG 3'h2

// fixed point roles under the clock debug code
`define TPSDP_PT_CLK60    0
`define TPSDP_PT_CLK30    1
`define TPSDP_PT_CLKVAR   2
`define TPSDP_PT_LOW      4
`define TPSDP_PT_CLK7P5   7
// points 3 to 6 carry levels: 3, 5 and 6 high, 4 low
`define TPSDP_LVL_MASK    8'h78
`define TPSDP_LVL_CLKDBG  8'h68

// reset values
`define TPSDP_STRAP_RST   3'h0
`define TPSDP_OE_OFF      8'h00

`endif

// File: rtl/tpsdp_pkg.sv
package tpsdp_pkg;

  // what a test point carries
  typedef enum logic [2:0] {
    src_hiz,
    src_low,
    src_high,
    src_clk60,
    src_clk30,
    src_clkvar,
    src_clk7p5
  } tpsdp_src_e;

  // pins held as inputs, or driven as outputs
  typedef enum logic {
    st_hold,
    st_run
  } tpsdp_state_e;

endpackage : tpsdp_pkg

// File: rtl/tpsdp_sync.sv
`timescale 1ns/1ns
`include "tpsdp_map.svh"

module tpsdp_sync (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     reset,
  // asynchronous levels in, synchronised levels out
  input  wire logic [`TPSDP_SYNC_W-1:0] async_in,
  output logic      [`TPSDP_SYNC_W-1:0] sync_out
);

  logic [`TPSDP_SYNC_W-1:0] meta_q;
  logic [`TPSDP_SYNC_W-1:0] sync_q;

  // two stages; the first is read only by the second
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : tpsdp_sync

// File: verif/tpsdp_board.sv
`timescale 1ns/1ns
// strap jumpers and pad pull-downs around the test point pads
module tpsdp_board (
  // jumpers, 1 = pull-up fitted
  input  wire logic [7:0] pull_up,
  // controller pad drive
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  // resolved pad levels
  output logic      [7:0] pad_level
);
  // a released pad settles to its pull level, never to its last driven value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_level[i] = pad_oe[i] ? pad_out[i] : pull_up[i];
    end
  end
endmodule : tpsdp_board

// File: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import tpsdp_pkg::*;
;
  logic       clock = 1'h0;
  logic       reset;
  logic       system_reset_low;
  logic [7:0] pull_up, pin_in, pin_out, pin_oe;
  logic       c60 = 1'h0, c30 = 1'h0, cvar = 1'h0, c7 = 1'h0;
  logic       sel_write;
  logic [2:0] sel_point, strap;
  tpsdp_src_e sel_source;
  logic       active;
  int         num_errors = 0, cmp_count = 0;

  // even half periods keep debug edges off the odd sample times
  always #25 clock = ~clock;
  always #8 c60 = ~c60;
  always #18 c30 = ~c30;
  always #22 cvar = ~cvar;
  always #66 c7 = ~c7;

  tpsdp_board board (.pull_up(pull_up), .pad_out(pin_out), .pad_oe(pin_oe),
    .pad_level(pin_in));

  tpsdp_port uut (.clock(clock), .reset(reset), .system_reset_low(system_reset_low),
    .test_point_bus_in(pin_in), .test_point_bus_out(pin_out),
    .test_point_bus_oe(pin_oe), .dbg_clk_60(c60), .dbg_clk_30(c30),
    .dbg_clk_var(cvar), .dbg_clk_7p5(c7), .sel_write(sel_write),
    .sel_point(sel_point), .sel_source(sel_source),
    .test_mode_strap_bits(strap), .port_active(active));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // strap glitches early in the pulse, settles before release
  task automatic rel(input logic [7:0] pu);
    @(negedge clock);
    pull_up = ~pu;
    system_reset_low = 1'h0;
    repeat (2) @(negedge clock);
    pull_up = pu;
    repeat (3) @(negedge clock);
    system_reset_low = 1'h1;
    repeat (5) @(negedge clock);
  endtask : rel

  // caller lowers sel_write, so two calls make back-to-back writes
  task automatic sel(input logic [2:0] pt, input tpsdp_src_e src);
    @(negedge clock);
    sel_write = 1'h1;
    sel_point = pt;
    sel_source = src;
  endtask : sel

  task automatic t_quiet();
    chk(pin_oe, 8'h00);
    chk({7'h0, active}, 8'h00);
    sel(3'h0, src_high);
    @(negedge clock);
    sel_write = 1'h0;
    // a write while held must be dropped
    chk(pin_oe, 8'h00);
    rel(8'h00);
    chk({7'h0, active}, 8'h01);
    chk({5'h0, strap}, 8'h00);
    chk(pin_oe, 8'h00);
    pull_up = 8'h07;
    repeat (5) @(negedge clock);
    chk({5'h0, strap}, 8'h00);
    chk(pin_oe, 8'h00);
    $display("test quiet done");
  endtask : t_quiet

  task automatic t_clk();
    rel(8'hfa);
    chk({5'h0, strap}, 8'h02);
    chk(pin_oe, 8'hff);
    chk(pin_out & 8'h78, 8'h68);
    // negedges fall on even times, so step to odd ones where no debug clock moves
    #1;
    for (int i = 0; i < 6; i++) begin
      #2;
      chk({4'h0, pin_out[7], pin_out[2:0]}, {4'h0, c7, cvar, c30, c60});
    end
    sel(3'h4, src_high);
    sel(3'h0, src_hiz);
    @(negedge clock);
    sel_write = 1'h0;
    chk(pin_oe, 8'hfe);
    chk(pin_out & 8'h78, 8'h78);
    sel(3'h6, src_low);
    @(negedge clock);
    sel_write = 1'h0;
    chk(pin_out & 8'h78, 8'h38);
    pull_up = 8'h00;
    repeat (5) @(negedge clock);
    chk({5'h0, strap}, 8'h02);
    system_reset_low = 1'h0;
    repeat (4) @(negedge clock);
    chk(pin_oe, 8'h00);
    chk({7'h0, active}, 8'h00);
    $display("test clock debug done");
  endtask : t_clk

  task automatic t_other();
    for (int c = 1; c < 8; c++) begin
      if (c == 2) continue;
      rel(8'(c));
      chk({5'h0, strap}, 8'(c));
      chk(pin_oe, 8'h00);
    end
    $display("test other codes done");
  endtask : t_other

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // about 125 cycles of tests, so this only trips on a hang
  initial begin
    repeat (3000) @(posedge clock);
    num_errors++;
    final_report();
  end

  initial begin
    reset = 1'h1;
    system_reset_low = 1'h0;
    pull_up = 8'h00;
    sel_write = 1'h0;
    sel_point = 3'h0;
    sel_source = src_hiz;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    repeat (3) @(negedge clock);
    t_quiet();
    t_clk();
    t_other();
    final_report();
  end
endmodule : tb_top
